// ==== logic/csd_pkg.sv ====
// package for the chip select address decoder: register map, field
// layout, reset values and the reserved address windows.
// assumes a 32-bit classic wishbone register port.
`default_nettype none
package csd_pkg;
  localparam int CSD_RANGES = 4;
  localparam logic [31:0] CSD_RANGE0_OFS = 32'hffffe400;
  localparam logic [31:0] CSD_RANGE1_OFS = 32'hffffe404;
  localparam logic [31:0] CSD_RANGE2_OFS = 32'hffffe408;
  localparam logic [31:0] CSD_RANGE3_OFS = 32'hffffe40c;
  localparam logic [31:0] CSD_STATUS_OFS = 32'hffffe410;
  localparam logic [29:0] CSD_RANGE_WORD0 = 30'h3ffff900;
  localparam logic [29:0] CSD_STATUS_WORD = 30'h3ffff904;
  localparam int CSD_BASE_LSB = 16;
  localparam int CSD_MASK_W = 16;
  // lowest masked address bit for ranges 0/1 and for ranges 2/3
  localparam int CSD_LOW_MASK_LSB = 14;
  localparam int CSD_HIGH_MASK_LSB = 15;
  localparam logic [15:0] CSD_LOW_MASK_RST = 16'h03ff;
  localparam logic [15:0] CSD_HIGH_MASK_RST = 16'h01ff;
  localparam logic [31:0] CSD_DATA_ZERO = 32'h00000000;
  // reserved windows where no select line is driven
  localparam logic [31:0] CSD_ROM_LO = 32'h1fc00000;
  localparam logic [31:0] CSD_ROM_HI = 32'h1fc7ffff;
  localparam logic [31:0] CSD_IO_LO = 32'h40000000;
  localparam logic [31:0] CSD_IO_HI = 32'h4007ffff;
  localparam logic [31:0] CSD_RAM_LO = 32'hffff8000;
  localparam logic [31:0] CSD_RAM_HI = 32'hffffbfff;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] mask;
  } csd_range_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } csd_wb_req_s;
endpackage : csd_pkg
`default_nettype wire

// ==== logic/csd_range_regs.sv ====
// four-word register file that holds the base/mask ranges.
// assumes writes come from the wishbone slave in the top module.
`default_nettype none
module csd_range_regs
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] idx_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [1:0] rd_idx_i,
  output logic [31:0] rd_dat_o,
  output csd_range_s ranges_o [CSD_RANGES]
);
  csd_range_s regs_ff [CSD_RANGES];
  csd_range_s nxt_regs [CSD_RANGES];
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;

  always_comb begin
    for (int i = 0; i < CSD_RANGES; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (wr_i && idx_i == i[1:0]) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) begin
            nxt_regs[i][b*8 +: 8] = dat_i[b*8 +: 8];
          end
        end
      end
    end
    nxt_rd = regs_ff[rd_idx_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < CSD_RANGES; i++) begin
        regs_ff[i].base <= '0;
        regs_ff[i].mask <= (i < 2) ? CSD_LOW_MASK_RST
                                   : CSD_HIGH_MASK_RST;
      end
      rd_ff <= CSD_DATA_ZERO;
    end else begin
      regs_ff <= nxt_regs;
      rd_ff <= nxt_rd;
    end
  end

  assign rd_dat_o = rd_ff;
  assign ranges_o = regs_ff;
endmodule : csd_range_regs
`default_nettype wire

// ==== logic/csd_decoder.sv ====
// chip select address decoder: four base/mask ranges drive four
// active-low select lines; registers sit on a classic wishbone slave.
// assumes bus_adr_i is a same-clock bus cycle address with bus_cyc_i.
//
// The Wishbone interface to the registers was left to the implementer.
`default_nettype none
module csd_decoder
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_cyc_i,
  input wire logic [31:0] bus_adr_i,
  output logic select_line_zero_n_o,
  output logic select_line_one_n_o,
  output logic select_line_two_n_o,
  output logic select_line_three_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // range match helpers

  // expand a range's base and mask to full 32-bit compare values
  function automatic logic [31:0] csd_care(input logic [15:0] mask,
                                           input int lsb);
    logic [31:0] ign;
    ign = '0;
    ign[lsb +: CSD_MASK_W] = mask;
    // bits under the mask field's lsb are inside the smallest block
    ign = ign | ((32'h1 << lsb) - 32'h1);
    return ~ign;
  endfunction : csd_care

  function automatic logic csd_hit(input logic [31:0] adr,
                                   input csd_range_s r,
                                   input int lsb);
    logic [31:0] start;
    start = {r.base, 16'h0000};
    return ((adr ^ start) & csd_care(r.mask, lsb)) == '0;
  endfunction : csd_hit

  // inclusive window test, shared by the three reserved windows
  function automatic logic csd_in_window(input logic [31:0] adr,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    return (adr >= lo) && (adr <= hi);
  endfunction : csd_in_window

  // reserved windows stay quiet even when a range covers them, so a
  // range spanning the rom or i/o area still steps around it
  function automatic logic csd_reserved(input logic [31:0] adr);
    return csd_in_window(adr, CSD_ROM_LO, CSD_ROM_HI) ||
           csd_in_window(adr, CSD_IO_LO, CSD_IO_HI) ||
           csd_in_window(adr, CSD_RAM_LO, CSD_RAM_HI);
  endfunction : csd_reserved

  // fixed priority: the lowest set index wins, so one grant bit at most
  function automatic logic [3:0] csd_first(input logic [3:0] hits);
    logic [3:0] one_hot;
    one_hot = 4'h0;
    unique casez (hits)
      4'b???1: one_hot = 4'h1;
      4'b??10: one_hot = 4'h2;
      4'b?100: one_hot = 4'h4;
      4'b1000: one_hot = 4'h8;
      default: one_hot = 4'h0;
    endcase
    return one_hot;
  endfunction : csd_first

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave

  csd_wb_req_s req;
  csd_range_s ranges [CSD_RANGES];
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [31:0] reg_rd;
  logic [29:0] word;
  logic is_range;
  logic is_status;
  logic wr_en;
  logic rd_pend_ff;
  logic nxt_rd_pend;
  logic [3:0] last_ff;
  logic [3:0] nxt_last;
  logic bus_req;

  assign req = '{cyc: wb_cyc_i,
                 stb: wb_stb_i,
                 we: wb_we_i,
                 sel: wb_sel_i,
                 adr: wb_adr_i,
                 dat: wb_dat_i};
  // the four range words share one aligned block; the low two word
  // bits pick the range
  assign word = req.adr[31:2];
  assign is_range = word[29:2] == CSD_RANGE_WORD0[29:2];
  assign is_status = word == CSD_STATUS_WORD;
  // a request counts as new until its ack has gone out, so a held
  // strobe never writes twice
  assign bus_req = req.cyc && req.stb && !ack_ff;
  assign wr_en = bus_req && req.we && is_range;

  // status and unmapped words are never written: only range words
  // reach the register file
  csd_range_regs csd_range_regs_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_en),
    .idx_i(word[1:0]),
    .sel_i(req.sel),
    .dat_i(req.dat),
    .rd_idx_i(word[1:0]),
    .rd_dat_o(reg_rd),
    .ranges_o(ranges)
  );

  // range reads take two cycles: one to load the memory's output register,
  // one to present it with ack
  always_comb begin
    nxt_ack = 1'b0;
    nxt_rd_pend = 1'b0;
    nxt_dat = dat_ff;
    if (bus_req) begin
      // writes, status and unmapped words answer at once; unmapped
      // reads return zero and unmapped writes are dropped
      if (req.we || !is_range) begin
        nxt_ack = 1'b1;
        nxt_dat = is_status ? {28'h0000000, last_ff} : CSD_DATA_ZERO;
      end else if (!rd_pend_ff) begin
        nxt_rd_pend = 1'b1;
      end else begin
        nxt_ack = 1'b1;
        nxt_dat = reg_rd;
      end
    end
    if (req.we) begin
      nxt_dat = CSD_DATA_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= CSD_DATA_ZERO;
      rd_pend_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      rd_pend_ff <= nxt_rd_pend;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  ////////////////////////////////////////////////////////////////////////
  // decode

  // selects are registered: the line for an address shows one edge
  // after the address is sampled and is redone every cycle
  logic [3:0] hit;
  logic [3:0] grant;
  logic [3:0] sel_n_ff;
  logic [3:0] nxt_sel_n;

  generate
    // ranges 0/1 start their mask at a14, ranges 2/3 at a15
    for (genvar g = 0; g < CSD_RANGES; g++) begin : g_hit
      localparam int LSB = (g < 2) ? CSD_LOW_MASK_LSB : CSD_HIGH_MASK_LSB;
      assign hit[g] = csd_hit(bus_adr_i, ranges[g], LSB);
    end
  endgenerate

  always_comb begin
    grant = 4'h0;
    if (bus_cyc_i && !csd_reserved(bus_adr_i)) begin
      grant = csd_first(hit);
    end
    nxt_sel_n = ~grant;
    nxt_last = (grant != 4'h0) ? grant : last_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_n_ff <= 4'hf;
      last_ff <= 4'h0;
    end else begin
      sel_n_ff <= nxt_sel_n;
      last_ff <= nxt_last;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // select outputs

  assign select_line_zero_n_o = sel_n_ff[0];
  assign select_line_one_n_o = sel_n_ff[1];
  assign select_line_two_n_o = sel_n_ff[2];
  assign select_line_three_n_o = sel_n_ff[3];

endmodule : csd_decoder
`default_nettype wire

// ==== test/csd_decoder_sva.sv ====
// checker for the select decoder, bound to its top module.
// assumes one clock and a synchronous active-high reset.
`default_nettype none
module csd_decoder_sva
  import csd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic bus_cyc_i,
  input wire logic [31:0] bus_adr_i,
  input wire logic select_line_zero_n_o,
  input wire logic select_line_one_n_o,
  input wire logic select_line_two_n_o,
  input wire logic select_line_three_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] sel_n;
  logic wr_ff, nxt_wr, clean;
  assign sel_n = {select_line_three_n_o, select_line_two_n_o,
    select_line_one_n_o, select_line_zero_n_o};
  // clean: ranges still hold their reset values
  assign clean = ~wr_ff & ~(wb_cyc_i & wb_stb_i & wb_we_i);
  always_comb begin
    nxt_wr = (wr_ff | (wb_cyc_i & wb_stb_i & wb_we_i)) & ~rst_i;
  end
  always_ff @(posedge clk_i) begin
    wr_ff <= nxt_wr;
  end
  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_in(logic [31:0] lo, hi);
    bus_cyc_i && bus_adr_i >= lo && bus_adr_i <= hi;
  endsequence
  a_single_select: assert property ($onehot0(~sel_n))
    else $error("two select lines low");
  a_idle_all_high: assert property (!bus_cyc_i |=> &sel_n)
    else $error("select without bus cycle");
  a_rom_hole_quiet: assert property (
    s_in(CSD_ROM_LO, CSD_ROM_HI) |=> &sel_n)
    else $error("select in rom window");
  a_io_hole_quiet: assert property (
    s_in(CSD_IO_LO, CSD_IO_HI) |=> &sel_n)
    else $error("select in io window");
  a_ram_hole_quiet: assert property (
    s_in(CSD_RAM_LO, CSD_RAM_HI) |=> &sel_n)
    else $error("select in ram window");
  a_reset_zero_wins: assert property (clean && bus_cyc_i &&
    bus_adr_i[31:24] == 8'h00 |=> sel_n == 4'he) else $error("range0 lost");
  a_reset_size_cap: assert property (clean && bus_cyc_i &&
    bus_adr_i[31:24] != 8'h00 |=> &sel_n) else $error("select past 16M");
  a_reset_quiet: assert property (
    $past(rst_i) |-> &sel_n && !wb_ack_o)
    else $error("outputs active after reset");
endmodule : csd_decoder_sva
bind csd_decoder csd_decoder_sva csd_decoder_sva_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .bus_cyc_i, .bus_adr_i,
  .select_line_zero_n_o, .select_line_one_n_o, .select_line_two_n_o,
  .select_line_three_n_o);
`default_nettype wire

// ==== test/csd_mem_model.sv ====
// external memories: report which device sees its select line low.
// assumes active-low selects straight from the decoder.
`default_nettype none
module csd_mem_model (
  input wire logic [3:0] sel_n_i,
  output logic [2:0] hit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // 0 none, 1..4 device, 7 several or unknown
  always_comb begin
    case (~sel_n_i)
      4'h0: hit_o = 3'h0;
      4'h1: hit_o = 3'h1;
      4'h2: hit_o = 3'h2;
      4'h4: hit_o = 3'h3;
      4'h8: hit_o = 3'h4;
      default: hit_o = 3'h7;
    endcase
  end
endmodule : csd_mem_model
`default_nettype wire

// ==== test/test_csd_decoder.sv ====
// bench: wishbone register access and address decode checks.
// assumes the memory model reports the selected device.
`default_nettype none
module test_csd_decoder
  import csd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0, rst_i = 1'h1, bus_cyc_i = 1'h0, wb_ack_o;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_sel_i = 4'h0, sel_n;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, bus_adr_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [2:0] hit;
  int fail_count = 0, samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  csd_decoder csd_decoder_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .bus_cyc_i, .bus_adr_i, .select_line_zero_n_o(sel_n[0]),
    .select_line_one_n_o(sel_n[1]), .select_line_two_n_o(sel_n[2]),
    .select_line_three_n_o(sel_n[3]));
  csd_mem_model csd_mem_model_inst (.sel_n_i(sel_n), .hit_o(hit));
  //////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic chk_dat(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_dat
  task automatic chk_hit(input logic [2:0] e);
    chk_dat({29'h0, hit}, {29'h0, e});
  endtask : chk_hit
  // one wishbone cycle; on a read d is the expected data
  task automatic acc(input logic we, input logic [31:0] a, d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hf};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 20) begin
      fail_count++;
      test_done();
    end else if (!we) begin
      chk_dat(wb_dat_o, d);
    end
  endtask : acc
  task automatic dec(input logic [31:0] a, input logic [2:0] e);
    @(posedge clk_i);
    bus_cyc_i <= 1'h1;
    bus_adr_i <= a;
    @(posedge clk_i);
    #1;
    chk_hit(e);
  endtask : dec
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1'h0, CSD_RANGE1_OFS, 32'h000003ff);
    acc(1'h0, CSD_RANGE3_OFS, 32'h000001ff);
    acc(1'h0, 32'hffffe414, 32'h0);
    dec(32'h00001234, 3'h1);
    dec(32'h40100000, 3'h0);
    dec(32'h80000000, 3'h0);
    acc(1'h1, CSD_RANGE0_OFS, 32'hc0000000);
    acc(1'h1, CSD_RANGE1_OFS, 32'hc0000003);
    acc(1'h0, CSD_RANGE1_OFS, 32'hc0000003);
    dec(32'hc0003ffc, 3'h1);
    dec(32'hc0004000, 3'h2);
    dec(32'hc0010000, 3'h0);
    dec(32'h00001234, 3'h3);
    acc(1'h1, CSD_RANGE2_OFS, 32'h1fc8000f);
    dec(32'h1fcffff0, 3'h3);
    dec(32'h1fd00000, 3'h0);
    dec(32'h00001234, 3'h4);
    dec(32'h80001234, 3'h0);
    acc(1'h1, CSD_RANGE2_OFS, 32'h1fc8001f);
    dec(32'h1fc00000, 3'h0);
    dec(32'h1fc80000, 3'h3);
    acc(1'h1, CSD_RANGE2_OFS, 32'h4000001f);
    dec(32'h40000000, 3'h0);
    dec(32'h40080000, 3'h3);
    acc(1'h1, CSD_RANGE3_OFS, 32'hffff0000);
    dec(32'hffff7ffc, 3'h4);
    acc(1'h1, CSD_RANGE3_OFS, 32'hffff0001);
    dec(32'hffff8000, 3'h0);
    dec(32'hffffc000, 3'h4);
    acc(1'h0, CSD_STATUS_OFS, 32'h00000008);
    @(posedge clk_i);
    bus_cyc_i <= 1'h0;
    @(posedge clk_i);
    #1;
    chk_hit(3'h0);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1'h0, CSD_RANGE3_OFS, 32'h000001ff);
    acc(1'h0, CSD_RANGE0_OFS, 32'h000003ff);
    dec(32'h00001234, 3'h1);
    test_done();
  end
endmodule : test_csd_decoder
`default_nettype wire
